// ---- core/otem_top.sv ----
// emulator bus core: run/pause control, overlay segment map, trace capture, event monitor
// assumes pod bus inputs are synchronous to pclk and hold across a bus cycle of several clocks
// Operation
// - run ends on operator stop, breakpoint, reset, or target error
// - manual stop or breakpoint leaves the core in pause with trace readable
// - run mode never holds or stretches processor bus cycles
// - trace keeps the newest 2046 bus cycles for review after stop
// - each entry holds address, data, status and 16 probe bits
// - cycles are recorded while event conditions gate tracing, or every run cycle while trace_all is set
// - trace may be read over the register port while running
// - overlay of 32K to 2M bytes placed in independent 2K segments
// - each segment holds one of target, read/write, read-only, illegal
// - unmapped segments default to the target attribute
// - control-side overlay writes always succeed, regardless of attribute
// - target write to read-only overlay halts run and flags an error
// - mapped overlay accesses go to overlay, with no added waits
// - events combine address, data, status, counter and probe comparisons
// - a match can break, gate trace, count and trigger independently
// - four groups of eight comparators, statements belong to one group
// - one group active at once; a match may switch groups
// - probe bit patterns qualify events and alone can break
//
// Local design decisions: the placing of the registers and the APB register port.
module otem_top
  import otem_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               cpu_cyc,
  input  wire logic               cpu_write,
  input  wire logic [ADDR_W-1:0]  cpu_addr,
  input  wire logic [DATA_W-1:0]  cpu_data,
  input  wire logic [STAT_W-1:0]  cpu_status,
  input  wire logic [PROBE_W-1:0] external_probe_inputs,
  input  wire logic               tgt_reset_n,
  input  wire logic               tgt_err,
  output logic                    emu_run,
  output logic                    pod_hold,
  output logic                    ovl_sel,
  output logic                    ovl_we,
  output logic      [ADDR_W-1:0]  ovl_addr,
  output logic                    host_ovl_we,
  output logic      [ADDR_W-1:0]  host_ovl_addr,
  output logic      [DATA_W-1:0]  host_ovl_data,
  output logic                    trig_out,
  output logic                    err_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    otem_mode_t                          mode;
    logic [5:0]                          cause;
    logic                                trace_all;
    logic [SEG_W-1:0]                    map_idx;
    logic [NSEG-1:0][1:0]                attr;
    logic [NSEG-1:0][BLK_W-1:0]          blk;
    logic [4:0]                          cmp_idx;
    logic [NGRP*NCMP-1:0][CMP_W-1:0]     val;
    logic [NGRP*NCMP-1:0][CMP_W-1:0]     mask;
    logic [NGRP*NCMP-1:0][1:0]           fld;
    logic [NGRP*NCMP-1:0][CFG_W-1:0]     stmt;
    logic [CNT_W-1:0]                    cnt;
    logic [1:0]                          grp;
    logic [TPTR_W-1:0]                   tage;
    logic [ADDR_W-1:0]                   haddr;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
    logic                                ovl_sel;
    logic                                ovl_we;
    logic [ADDR_W-1:0]                   ovl_addr;
    logic                                host_we;
    logic [DATA_W-1:0]                   hdata;
    logic                                trig;
    logic                                tr_wr;
    logic [TRACE_W-1:0]                  tr_data;
    logic                                tr_clr;
  } otem_state_t;

  otem_state_t q;
  otem_state_t n;

  logic [NCMP-1:0]          cmp_hit;
  logic [NCMP-1:0]          st_hit;
  logic [TRACE_W-1:0]       tr_rd;
  logic [TPTR_W-1:0]        tr_cnt;
  logic [SEG_W-1:0]         seg;
  otem_attr_t               seg_attr;
  logic                     brk_any;
  logic                     trc_any;
  logic                     cnt_any;
  logic                     trg_any;
  logic                     goto_any;
  logic [1:0]               goto_grp;
  logic                     setup;
  logic                     access;
  logic                     mapped;
  logic [31:0]              rdata;
  logic [4:0]               ci;

  // ****************************************************************
  // event comparators of the active group
  // ****************************************************************
  genvar k;
  generate
    for (k = 0; k < NCMP; k++)
    begin : g_cmp
      otem_cmp u_cmp (
        .fld   (q.fld[{q.grp, 3'(k)}]),
        .val   (q.val[{q.grp, 3'(k)}]),
        .mask  (q.mask[{q.grp, 3'(k)}]),
        .addr  (cpu_addr),
        .data  (cpu_data),
        .stat  (cpu_status),
        .probe (external_probe_inputs),
        .hit   (cmp_hit[k])
      );
      assign st_hit[k] = otem_stmt_hit(q.stmt[{q.grp, 3'(k)}], cmp_hit, q.cnt == '0);
    end
  endgenerate

  otem_trace_buf u_tbuf (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (q.tr_wr),
    .wr_data (q.tr_data),
    .clear   (q.tr_clr),
    .rd_age  (q.tage),
    .rd_data (tr_rd),
    .count   (tr_cnt)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    n = q;
    n.ovl_we  = 1'b0;
    n.host_we = 1'b0;
    n.trig    = 1'b0;
    n.tr_wr   = 1'b0;
    n.tr_clr  = 1'b0;
    ci        = q.cmp_idx;

    // segment lookup is combinational so overlay steering lands in the same bus cycle
    seg      = cpu_addr[ADDR_W-1:SEG_SHIFT];
    seg_attr = otem_attr_t'(q.attr[seg]);

    brk_any  = 1'b0;
    trc_any  = 1'b0;
    cnt_any  = 1'b0;
    trg_any  = 1'b0;
    goto_any = 1'b0;
    goto_grp = q.grp;
    // lowest-numbered matching statement decides the next group
    for (int i = NCMP - 1; i >= 0; i--)
    begin
      if (st_hit[i])
      begin
        brk_any = brk_any | q.stmt[{q.grp, 3'(i)}][SC_BRK];
        trc_any = trc_any | q.stmt[{q.grp, 3'(i)}][SC_TRC];
        cnt_any = cnt_any | q.stmt[{q.grp, 3'(i)}][SC_CNT];
        trg_any = trg_any | q.stmt[{q.grp, 3'(i)}][SC_TRG];
        if (q.stmt[{q.grp, 3'(i)}][SC_GOTO])
        begin
          goto_any = 1'b1;
          goto_grp = q.stmt[{q.grp, 3'(i)}][SC_GGRP +: 2];
        end
      end
    end

    // register read mux
    mapped = 1'b1;
    case (paddr)
      OFF_CTRL:   rdata = {29'h0, q.trace_all, 2'b00};
      OFF_STATUS: rdata = {18'h0, q.cause, 7'h00, q.mode == OTEM_ST_RUN};
      OFF_MAP:    rdata = {10'h0, q.attr[q.map_idx], q.blk[q.map_idx], q.map_idx};
      OFF_CSEL:   rdata = {27'h0, q.cmp_idx};
      OFF_CVAL:   rdata = {8'h00, q.val[ci]};
      OFF_CMASK:  rdata = {8'h00, q.mask[ci]};
      OFF_CCFG:   rdata = {13'h0, q.stmt[ci], q.fld[ci]};
      OFF_CNT:    rdata = {16'h0000, q.cnt};
      OFF_GROUP:  rdata = {30'h0, q.grp};
      OFF_TPTR:   rdata = {21'h0, tr_cnt};
      OFF_TADDR:  rdata = {7'h00, tr_rd[ADDR_W+STAT_W-1:0]};
      OFF_TDATA:  rdata = tr_rd[TRACE_W-1:ADDR_W+STAT_W];
      OFF_HADDR:  rdata = {11'h000, q.haddr};
      OFF_HDATA:  rdata = {16'h0000, q.hdata};
      default:
      begin
        rdata  = 32'h00000000;
        mapped = 1'b0;
      end
    endcase

    // ****************************************************************
    // APB slave: one access cycle, no waits
    // ****************************************************************
    setup  = psel && !penable;
    access = psel && penable && q.pready;
    if (setup)
    begin
      n.pready  = 1'b1;
      n.pslverr = !mapped;
      n.prdata  = pwrite ? 32'h00000000 : rdata;
    end
    else if (access)
    begin
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      n.prdata  = 32'h00000000;
    end
    if (access && pwrite && !q.pslverr)
    begin
      case (paddr)
        OFF_CTRL:
        begin
          n.trace_all = pwdata[CTRL_TALL];
          n.tr_clr    = pwdata[CTRL_TCLR];
          if (pwdata[CTRL_RUN] && q.mode == OTEM_ST_PAUSE)
          begin
            n.mode  = OTEM_ST_RUN;
            n.cause = '0;
          end
        end
        OFF_MAP:
        begin
          n.map_idx = pwdata[SEG_W-1:0];
          n.blk[pwdata[SEG_W-1:0]]  = pwdata[SEG_W +: BLK_W];
          n.attr[pwdata[SEG_W-1:0]] = pwdata[SEG_W+BLK_W +: 2];
        end
        OFF_CSEL:   n.cmp_idx  = pwdata[4:0];
        OFF_CVAL:   n.val[ci]  = pwdata[CMP_W-1:0];
        OFF_CMASK:  n.mask[ci] = pwdata[CMP_W-1:0];
        OFF_CCFG:
        begin
          n.fld[ci]  = pwdata[1:0];
          n.stmt[ci] = pwdata[2 +: CFG_W];
        end
        OFF_CNT:    n.cnt   = pwdata[CNT_W-1:0];
        OFF_GROUP:  n.grp   = pwdata[1:0];
        OFF_TPTR:   n.tage  = pwdata[TPTR_W-1:0];
        OFF_HADDR:  n.haddr = pwdata[ADDR_W-1:0];
        OFF_HDATA:
        begin
          // control-side write goes straight to overlay, map attribute is not consulted
          n.hdata   = pwdata[DATA_W-1:0];
          n.host_we = 1'b1;
        end
        default:
        begin
        end
      endcase
    end

    // ****************************************************************
    // target bus cycle: overlay steering, events, trace
    // ****************************************************************
    if (cpu_cyc)
    begin
      // target attribute is the reset value, so unmapped segments fall through
      n.ovl_sel  = (seg_attr == OTEM_ATTR_RW) || (seg_attr == OTEM_ATTR_RO);
      n.ovl_we   = cpu_write && (seg_attr == OTEM_ATTR_RW);
      n.ovl_addr = {q.blk[seg], cpu_addr[SEG_SHIFT-1:0]};
    end
    if (cpu_cyc && q.mode == OTEM_ST_RUN)
    begin
      if ((q.trace_all || trc_any) && !q.tr_clr)
      begin
        n.tr_wr   = 1'b1;
        n.tr_data = {external_probe_inputs, cpu_data, cpu_status, cpu_addr};
      end
      if (cnt_any && q.cnt != '0)
        n.cnt = q.cnt - 1'b1;
      n.trig = trg_any;
      if (goto_any)
        n.grp = goto_grp;
      if (brk_any)
        n.cause[CS_BREAK] = 1'b1;
      if (cpu_write && seg_attr == OTEM_ATTR_RO)
        n.cause[CS_ROERR] = 1'b1;
      if (seg_attr == OTEM_ATTR_ILL)
        n.cause[CS_ILLERR] = 1'b1;
    end

    // ****************************************************************
    // run control
    // ****************************************************************
    if (q.mode == OTEM_ST_RUN)
    begin
      if (access && pwrite && paddr == OFF_CTRL && pwdata[CTRL_STOP])
        n.cause[CS_STOP] = 1'b1;
      if (tgt_err)
        n.cause[CS_TGTERR] = 1'b1;
    end
    if (!tgt_reset_n)
      n.cause[CS_RESET] = 1'b1;
    // any latched cause drops to pause, where trace and registers are open
    if (n.cause != '0)
      n.mode = OTEM_ST_PAUSE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      for (int i = 0; i < NGRP * NCMP; i++)
      begin
        q.mask[i] <= MASK_RST;
      end
      q.cnt <= CNT_RST;
    end
    else
      q <= n;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign emu_run       = q.mode == OTEM_ST_RUN;
  // hold only in pause; running cycles are never stretched
  assign pod_hold      = q.mode == OTEM_ST_PAUSE;
  assign ovl_sel       = q.ovl_sel;
  assign ovl_we        = q.ovl_we;
  assign ovl_addr      = q.ovl_addr;
  assign host_ovl_we   = q.host_we;
  assign host_ovl_addr = q.haddr;
  assign host_ovl_data = q.hdata;
  assign trig_out      = q.trig;
  assign err_out       = q.cause[CS_TGTERR] | q.cause[CS_ROERR] | q.cause[CS_ILLERR];

endmodule : otem_top

// ---- core/otem_pkg.sv ----
// constants, types and helpers shared by the overlay, trace and event monitor core
// assumes one 200 MHz clock and an APB register port with 12-bit byte offsets
package otem_pkg;

  // ****************************************************************
  // bus, overlay and trace dimensions
  // ****************************************************************
  localparam int ADDR_W      = 21;
  localparam int DATA_W      = 16;
  localparam int STAT_W      = 4;
  localparam int PROBE_W     = 16;
  localparam int SEG_SHIFT   = 11;
  localparam int SEG_W       = ADDR_W - SEG_SHIFT;
  localparam int NSEG        = 1 << SEG_W;
  localparam int OVL_MIN_KB  = 32;
  localparam int OVL_MAX_KB  = 2048;
  localparam int SEG_KB      = 2;
  localparam int NBLK        = OVL_MAX_KB / SEG_KB;
  localparam int BLK_W       = 10;
  localparam int TRACE_DEPTH = 2046;
  localparam int TPTR_W      = 11;
  localparam int TRACE_W     = PROBE_W + DATA_W + STAT_W + ADDR_W;
  localparam int NGRP        = 4;
  localparam int NCMP        = 8;
  localparam int CMP_W       = 24;
  localparam int CFG_W       = 17;
  localparam int CNT_W       = 16;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MAP    = 12'h008;
  localparam logic [11:0] OFF_CSEL   = 12'h00C;
  localparam logic [11:0] OFF_CVAL   = 12'h010;
  localparam logic [11:0] OFF_CMASK  = 12'h014;
  localparam logic [11:0] OFF_CCFG   = 12'h018;
  localparam logic [11:0] OFF_CNT    = 12'h01C;
  localparam logic [11:0] OFF_GROUP  = 12'h020;
  localparam logic [11:0] OFF_TPTR   = 12'h024;
  localparam logic [11:0] OFF_TADDR  = 12'h028;
  localparam logic [11:0] OFF_TDATA  = 12'h02C;
  localparam logic [11:0] OFF_HADDR  = 12'h030;
  localparam logic [11:0] OFF_HDATA  = 12'h034;

  // ctrl and status bit positions
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_TALL  = 2;
  localparam int CTRL_TCLR  = 3;
  localparam int CS_STOP    = 0;
  localparam int CS_BREAK   = 1;
  localparam int CS_RESET   = 2;
  localparam int CS_TGTERR  = 3;
  localparam int CS_ROERR   = 4;
  localparam int CS_ILLERR  = 5;
  localparam int STAT_CAUSE = 8;

  // statement config bit positions
  localparam int SC_AND   = 0;
  localparam int SC_UCNT  = 8;
  localparam int SC_BRK   = 9;
  localparam int SC_TRC   = 10;
  localparam int SC_CNT   = 11;
  localparam int SC_TRG   = 12;
  localparam int SC_GOTO  = 13;
  localparam int SC_GGRP  = 14;
  localparam int SC_EN    = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CMP_W-1:0] MASK_RST = 24'h000000;

  typedef enum logic [1:0] {
    OTEM_ATTR_TARGET = 2'b00,
    OTEM_ATTR_RW     = 2'b01,
    OTEM_ATTR_RO     = 2'b10,
    OTEM_ATTR_ILL    = 2'b11
  } otem_attr_t;

  typedef enum logic [1:0] {
    OTEM_FLD_ADDR  = 2'b00,
    OTEM_FLD_DATA  = 2'b01,
    OTEM_FLD_STAT  = 2'b10,
    OTEM_FLD_PROBE = 2'b11
  } otem_fld_t;

  typedef enum logic {
    OTEM_ST_PAUSE = 1'b0,
    OTEM_ST_RUN   = 1'b1
  } otem_mode_t;

  // statement fires when enabled, all selected comparators hit and counter gate passes
  function automatic logic otem_stmt_hit(input logic [CFG_W-1:0] cfg,
                                         input logic [NCMP-1:0]  hits,
                                         input logic             cnt_zero);
    logic [NCMP-1:0] sel;
    sel = cfg[SC_AND +: NCMP];
    return cfg[SC_EN] && ((hits & sel) == sel) && (!cfg[SC_UCNT] || cnt_zero);
  endfunction : otem_stmt_hit

endpackage : otem_pkg

// ---- core/otem_cmp.sv ----
// one event comparator: masked compare of a selected bus field
// assumes all inputs are stable within the bus cycle being judged
module otem_cmp
  import otem_pkg::*;
(
  input  wire logic [1:0]         fld,
  input  wire logic [CMP_W-1:0]   val,
  input  wire logic [CMP_W-1:0]   mask,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [DATA_W-1:0]  data,
  input  wire logic [STAT_W-1:0]  stat,
  input  wire logic [PROBE_W-1:0] probe,
  output logic                    hit
);

  logic [CMP_W-1:0] sample;

  always_comb
  begin
    case (otem_fld_t'(fld))
      OTEM_FLD_ADDR:  sample = CMP_W'(addr);
      OTEM_FLD_DATA:  sample = CMP_W'(data);
      OTEM_FLD_STAT:  sample = CMP_W'(stat);
      OTEM_FLD_PROBE: sample = CMP_W'(probe);
      default:        sample = '0;
    endcase
    // a clear mask bit is a don't-care; an all-zero mask always hits
    hit = ((sample ^ val) & mask) == '0;
  end

endmodule : otem_cmp

// ---- core/otem_trace_buf.sv ----
// circular trace store in flops with an age-indexed read port
// assumes writes are single-cycle pulses; reads are combinational
module otem_trace_buf
  import otem_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               wr_en,
  input  wire logic [TRACE_W-1:0] wr_data,
  input  wire logic               clear,
  input  wire logic [TPTR_W-1:0]  rd_age,
  output logic      [TRACE_W-1:0] rd_data,
  output logic      [TPTR_W-1:0]  count
);

  typedef struct packed {
    logic [TRACE_DEPTH-1:0][TRACE_W-1:0] mem;
    logic [TPTR_W-1:0]                   wptr;
    logic [TPTR_W-1:0]                   cnt;
  } otem_tbuf_t;

  otem_tbuf_t q;
  otem_tbuf_t n;
  logic [TPTR_W:0] idx;

  always_comb
  begin
    n = q;
    if (clear)
    begin
      n.wptr = '0;
      n.cnt  = '0;
    end
    else if (wr_en)
    begin
      // oldest entry is overwritten so the newest cycles survive a stop
      n.mem[q.wptr] = wr_data;
      n.wptr = (q.wptr == TPTR_W'(TRACE_DEPTH - 1)) ? '0 : q.wptr + 1'b1;
      if (q.cnt != TPTR_W'(TRACE_DEPTH))
        n.cnt = q.cnt + 1'b1;
    end
    // age 0 is the most recent entry
    if ({1'b0, q.wptr} > {1'b0, rd_age})
      idx = {1'b0, q.wptr} - {1'b0, rd_age} - 1'b1;
    else
      idx = {1'b0, q.wptr} + (TPTR_W + 1)'(TRACE_DEPTH) - {1'b0, rd_age} - 1'b1;
    if (idx < (TPTR_W + 1)'(TRACE_DEPTH))
      rd_data = q.mem[idx[TPTR_W-1:0]];
    else
      rd_data = '0;
    count = q.cnt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= n;
  end

endmodule : otem_trace_buf

// ---- testbench/otem_tgt_model.sv ----
// target bus model: issues one-clock bus cycles toward the core
// assumes it shares pclk with the core and is driven by task calls
module otem_tgt_model
  import otem_pkg::*;
(
  input  wire logic               pclk,
  output logic                    cpu_cyc,
  output logic                    cpu_write,
  output logic      [ADDR_W-1:0]  cpu_addr,
  output logic      [DATA_W-1:0]  cpu_data,
  output logic      [STAT_W-1:0]  cpu_status,
  output logic      [PROBE_W-1:0] external_probe_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // bus cycle
  // ****************
  initial
  begin
    cpu_cyc = 1'b0;
    {cpu_write, cpu_addr, cpu_data, cpu_status, external_probe_inputs} = '0;
  end
  // released address and data lines go inverted so a stale value can never pass for a fresh one
  task automatic cycle(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [STAT_W-1:0] s, input logic [PROBE_W-1:0] p);
    @(posedge pclk);
    cpu_cyc <= 1'b1;
    {cpu_write, cpu_addr, cpu_data, cpu_status, external_probe_inputs} <= {w, a, d, s, p};
    @(posedge pclk);
    cpu_cyc  <= 1'b0;
    cpu_addr <= ~a;
    cpu_data <= ~d;
  endtask : cycle
endmodule : otem_tgt_model

// ---- testbench/otem_top_checker.sv ----
// port-level checker for the overlay, trace and event core
// assumes it is bound onto otem_top; pclk is the only clock
module otem_top_checker
  import otem_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              cpu_cyc,
  input wire logic              cpu_write,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic              tgt_reset_n,
  input wire logic              tgt_err,
  input wire logic              emu_run,
  input wire logic              pod_hold,
  input wire logic              ovl_sel,
  input wire logic              ovl_we,
  input wire logic [ADDR_W-1:0] ovl_addr,
  input wire logic              host_ovl_we,
  input wire logic              trig_out,
  input wire logic              err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready");
  a_run_no_hold: assert property (pod_hold == !emu_run)
    else $error("hold while running");
  a_tgterr_stops: assert property (emu_run && tgt_err |=> !emu_run)
    else $error("target error kept run");
  a_tgtrst_stops: assert property (!tgt_reset_n |=> !emu_run)
    else $error("target reset kept run");
  a_err_halts: assert property ($rose(err_out) |-> !emu_run)
    else $error("error while running");
  a_ovl_low_bits: assert property ($past(cpu_cyc) |-> ovl_addr[10:0] == $past(cpu_addr[10:0]))
    else $error("overlay offset wrong");
  a_ovl_we_cause: assert property (ovl_we |-> ovl_sel && $past(cpu_cyc && cpu_write))
    else $error("stray overlay write");
  a_trig_cause: assert property (trig_out |-> $past(cpu_cyc && emu_run))
    else $error("stray trigger");
  a_host_we_cause: assert property (host_ovl_we |->
    $past(psel && penable && pwrite && pready && paddr == OFF_HDATA))
    else $error("stray host write");
  c_trig: cover property (trig_out);
  c_break: cover property ($fell(emu_run) && !err_out);
  c_ovl_write: cover property (ovl_we);
endmodule : otem_top_checker

// ---- testbench/tb.sv ----
// self-checking bench for otem_top: APB master, target bus model, checker bind
// assumes the package constants and the designer's register layout
module tb
  import otem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               pclk, presetn, psel, penable, pwrite, tgt_reset_n, tgt_err, er;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               pready, pslverr, cpu_cyc, cpu_write, emu_run, pod_hold, ovl_sel, ovl_we;
  logic               host_ovl_we, trig_out, err_out;
  logic [ADDR_W-1:0]  cpu_addr, ovl_addr, host_ovl_addr;
  logic [DATA_W-1:0]  cpu_data, host_ovl_data;
  logic [STAT_W-1:0]  cpu_status;
  logic [PROBE_W-1:0] external_probe_inputs;
  int                 n_fail = 0;
  int                 total_checks = 0;
  otem_top dut (.*);
  otem_tgt_model u_tgt (.pclk(pclk), .cpu_cyc(cpu_cyc), .cpu_write(cpu_write),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_status(cpu_status),
    .external_probe_inputs(external_probe_inputs));
  always #2.5 pclk = ~pclk;
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // the wait on ready is bounded by the watchdog alone
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    chk(pod_hold, 32'h1);
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_CNT, CNT_RST);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(er, 32'h1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_overlay;
    apb(1'b1, OFF_MAP, 32'h00101401);
    apb(1'b1, OFF_MAP, 32'h00201802);
    apb(1'b1, OFF_MAP, 32'h00300003);
    apb(1'b1, OFF_CTRL, 32'h1);
    u_tgt.cycle(1'b1, 21'h000923, 16'h1111, 4'h1, 16'h0);
    #1;
    chk(ovl_sel, 32'h1);
    chk(ovl_we, 32'h1);
    chk(ovl_addr, 32'h00002923);
    chk(pod_hold, 32'h0);
    u_tgt.cycle(1'b0, 21'h002010, 16'h0, 4'h1, 16'h0);
    #1;
    chk(ovl_sel, 32'h0);
    u_tgt.cycle(1'b1, 21'h001010, 16'h2222, 4'h1, 16'h0);
    #1;
    chk(ovl_we, 32'h0);
    rdc(OFF_STATUS, 32'h1000);
    chk(err_out, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    u_tgt.cycle(1'b0, 21'h001810, 16'h0, 4'h1, 16'h0);
    rdc(OFF_STATUS, 32'h2000);
    apb(1'b1, OFF_HADDR, 32'h1010);
    apb(1'b1, OFF_HDATA, 32'hBEEF);
    #1;
    chk(host_ovl_we, 32'h1);
    chk(host_ovl_addr, 32'h1010);
    chk(host_ovl_data, 32'hBEEF);
    $display("t_overlay done");
  endtask : t_overlay
  task automatic t_event;
    apb(1'b1, OFF_CSEL, 32'h8);
    apb(1'b1, OFF_CCFG, 32'h40804);
    apb(1'b1, OFF_CSEL, 32'h0);
    apb(1'b1, OFF_CVAL, 32'hA5C3);
    apb(1'b1, OFF_CMASK, 32'hFFFF);
    apb(1'b1, OFF_CCFG, 32'h44807);
    apb(1'b1, OFF_CTRL, 32'h1);
    u_tgt.cycle(1'b0, 21'h10, 16'h0, 4'h1, 16'h1111);
    #1;
    chk(trig_out, 32'h0);
    rdc(OFF_STATUS, 32'h1);
    u_tgt.cycle(1'b0, 21'h10, 16'h0, 4'h1, 16'hA5C3);
    #1;
    chk(trig_out, 32'h1);
    rdc(OFF_STATUS, 32'h200);
    apb(1'b1, OFF_GROUP, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    u_tgt.cycle(1'b0, 21'h10, 16'h0, 4'h1, 16'h0);
    rdc(OFF_STATUS, 32'h200);
    apb(1'b1, OFF_GROUP, 32'h0);
    $display("t_event done");
  endtask : t_event
  task automatic t_trace;
    apb(1'b1, OFF_CTRL, 32'h8);
    apb(1'b1, OFF_CTRL, 32'h5);
    u_tgt.cycle(1'b1, 21'h000345, 16'h1234, 4'h5, 16'hCAFE);
    u_tgt.cycle(1'b0, 21'h01FFFF, 16'h5678, 4'hA, 16'h0F0F);
    rdc(OFF_TPTR, 32'h2);
    apb(1'b1, OFF_TPTR, 32'h0);
    rdc(OFF_TADDR, 32'h0141FFFF);
    rdc(OFF_TDATA, 32'h0F0F5678);
    apb(1'b1, OFF_TPTR, 32'h1);
    rdc(OFF_TADDR, 32'h00A00345);
    apb(1'b1, OFF_CTRL, 32'h2);
    rdc(OFF_STATUS, 32'h100);
    u_tgt.cycle(1'b0, 21'h10, 16'h0, 4'h1, 16'h0);
    rdc(OFF_TPTR, 32'h2);
    $display("t_trace done");
  endtask : t_trace
  task automatic t_errs;
    apb(1'b1, OFF_CTRL, 32'h1);
    @(posedge pclk);
    tgt_err <= 1'b1;
    @(posedge pclk);
    tgt_err <= 1'b0;
    rdc(OFF_STATUS, 32'h800);
    chk(err_out, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    @(posedge pclk);
    tgt_reset_n <= 1'b0;
    @(posedge pclk);
    tgt_reset_n <= 1'b1;
    rdc(OFF_STATUS, 32'h400);
    $display("t_errs done");
  endtask : t_errs
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, tgt_err} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tgt_reset_n = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_overlay;
    t_event;
    t_trace;
    t_errs;
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out;
  end
endmodule : tb
bind otem_top otem_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .cpu_cyc(cpu_cyc),
  .cpu_write(cpu_write), .cpu_addr(cpu_addr), .tgt_reset_n(tgt_reset_n), .tgt_err(tgt_err),
  .emu_run(emu_run), .pod_hold(pod_hold), .ovl_sel(ovl_sel), .ovl_we(ovl_we),
  .ovl_addr(ovl_addr), .host_ovl_we(host_ovl_we), .trig_out(trig_out), .err_out(err_out));
